// ==== core/raa_alert_bank.sv ====
// sticky alert cause flags with read-then-conversion-complete clearing
`timescale 1ns/1ps
module raa_alert_bank
    import raa_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // enabled trip conditions, held while the condition is present
    input wire raa_pkg::raa_alert_t trip,
    // host read of the cause register and end of a conversion cycle
    input wire logic read_strobe,
    input wire logic conv_done,
    // flags
    output raa_pkg::raa_alert_t status
);
    import raa_pkg::*;

    logic [23:0] status_reg, status_next;
    logic [23:0] marked_reg, marked_next;

    ////////////////////////////////////////////////////////////////////////////
    // a read only arms the clear; the clear lands when the cycle completes
    always_comb begin
        status_next = status_reg;
        marked_next = marked_reg;
        if (read_strobe) begin
            marked_next = marked_reg | status_reg;
        end
        if (conv_done) begin
            // bits read but still tripped survive the clear
            status_next = status_reg & ~(marked_next & ~trip);
            marked_next = '0;
        end
        // setting beats a clear landing in the same cycle
        status_next = status_next | trip;
        status_next[1:0] = 2'b00;
    end

    // flags move without any snapshot command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_reg <= RAA_ALERT_RESET;
            marked_reg <= '0;
        end else begin
            status_reg <= status_next;
            marked_reg <= marked_next;
        end
    end

    assign status = raa_alert_t'(status_reg);

endmodule : raa_alert_bank

// ==== core/raa_pkg.sv ====
// package: offsets, field layouts, reset values and timing for the range/accumulator/alert bank
package raa_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets on the management bus register pointer
    localparam logic [7:0] RAA_OFS_LATCHED_RANGE = 8'h24;
    localparam logic [7:0] RAA_OFS_ACCUM_MODE = 8'h25;
    localparam logic [7:0] RAA_OFS_ALERT_CAUSE = 8'h26;

    // register widths and reset values
    localparam int RAA_DATA_W = 24;
    localparam logic [15:0] RAA_RANGE_RESET = 16'h0000;
    localparam logic [7:0] RAA_ACCUM_RESET = 8'h00;
    localparam logic [23:0] RAA_ALERT_RESET = 24'h00_0000;

    // field positions (low bit of each field)
    localparam int RAA_POS_SENSE_CH4 = 8;
    localparam int RAA_POS_BUS_CH1 = 6;
    localparam int RAA_POS_BUS_CH2 = 4;
    localparam int RAA_POS_BUS_CH3 = 2;
    localparam int RAA_POS_BUS_CH4 = 0;
    localparam int RAA_POS_ACC_CH1 = 6;
    localparam int RAA_POS_ACC_CH2 = 4;
    localparam int RAA_POS_ACC_CH3 = 2;
    localparam int RAA_POS_ACC_CH4 = 0;
    localparam int RAA_POS_OC = 20;
    localparam int RAA_POS_UC = 16;
    localparam int RAA_POS_OV = 12;
    localparam int RAA_POS_UV = 8;
    localparam int RAA_POS_OP = 4;
    localparam int RAA_POS_ACCUMULATOR_OVERFLOW_FLAG = 3;
    localparam int RAA_POS_CNT_OVF = 2;

    // snapshot-valid delay: 1 ms at the 125 MHz device clock
    localparam int RAA_CLK_HZ = 125_000_000;
    localparam int RAA_LATCH_VALID_US = 1000;
    localparam int RAA_LATCH_VALID_CYC = RAA_CLK_HZ / 1_000_000 * RAA_LATCH_VALID_US;

    ////////////////////////////////////////////////////////////////////////////
    // full-scale range codes, sense and bus fields share one encoding
    typedef enum logic [1:0] {
        RAA_FSR_UNIPOLAR = 2'b00,
        RAA_FSR_BIPOLAR = 2'b01,
        RAA_FSR_BIPOLAR_HALF = 2'b10,
        RAA_FSR_RESERVED = 2'b11
    } raa_fsr_t;

    // accumulator source codes
    typedef enum logic [1:0] {
        RAA_ACC_POWER = 2'b00,
        RAA_ACC_SENSE = 2'b01,
        RAA_ACC_BUS = 2'b10,
        RAA_ACC_RSVD = 2'b11
    } raa_acc_t;

    // alert cause layout, msb first, channel 1 in the top bit of each nibble
    typedef struct packed {
        logic [3:0] over_current;
        logic [3:0] under_current;
        logic [3:0] over_voltage;
        logic [3:0] under_voltage;
        logic [3:0] over_power;
        logic accumulator_overflow;
        logic sample_count_overflow;
        logic [1:0] unused;
    } raa_alert_t;

    // register access strobes from the two-wire bus engine
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [23:0] wdata;
    } raa_req_t;

    // range settings decoded for the measurement path
    typedef struct packed {
        raa_fsr_t sense_range_ch4;
        raa_fsr_t bus_range_ch1;
        raa_fsr_t bus_range_ch2;
        raa_fsr_t bus_range_ch3;
        raa_fsr_t bus_range_ch4;
    } raa_range_t;

endpackage : raa_pkg

// ==== core/raa_regs.sv ====
// latched range, accumulator mode and alert cause registers of a four-channel power monitor
`timescale 1ns/1ps
module raa_regs
    import raa_pkg::*;
#(
    parameter int LATCH_VALID_CYC = raa_pkg::RAA_LATCH_VALID_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register access from the two-wire bus engine
    input wire raa_pkg::raa_req_t req,
    output logic [23:0] rd_data,
    output logic rd_valid,
    // snapshot command and the live range settings it freezes
    input wire logic snapshot_cmd,
    input wire logic [15:0] range_live,
    // comparator results and alert enables, bit layout as the cause register
    input wire raa_pkg::raa_alert_t compare_hit,
    input wire raa_pkg::raa_alert_t alert_enable,
    // accumulator overflow and fullness limit per channel, channel 1 in bit 3
    input wire logic [3:0] acc_overflow,
    input wire logic [3:0] acc_limit_hit,
    input wire logic count_overflow,
    input wire logic conv_done,
    // decoded settings for the measurement path
    output raa_pkg::raa_range_t range_latched,
    output logic latched_valid,
    output logic [7:0] accum_mode,
    output raa_pkg::raa_alert_t alert_flags
);
    import raa_pkg::*;

    // load value of the snapshot settling counter; 24 bits cover the full 1 ms
    // at the device clock, and a smaller parameter only shortens the wait
    // a parameter too large for 24 bits would wrap, so keep it under that range
    localparam logic [23:0] CNT_LOAD = 24'(LATCH_VALID_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // reserved accumulator codes behave and read as power mode
    // cleaning on write rather than on read keeps the stored mode and the mode
    // used by the accumulator path identical, so no reserved code reaches it
    function automatic logic [7:0] acc_clean(input logic [7:0] raw);
        logic [7:0] v;
        v = raw;
        for (int i = 0; i < 4; i++) begin
            if (raw[2*i +: 2] == RAA_ACC_RSVD) begin
                v[2*i +: 2] = RAA_ACC_POWER;
            end
        end
        return v;
    endfunction : acc_clean

    // pull a range field out of the latched word
    // shared by all five fields so the field positions live only in the package
    function automatic raa_fsr_t fsr_at(input logic [15:0] word, input int pos);
        return raa_fsr_t'(word[pos +: 2]);
    endfunction : fsr_at

    ////////////////////////////////////////////////////////////////////////////
    // configuration state
    logic [15:0] range_reg, range_next;
    logic [7:0] accum_reg, accum_next;
    logic [23:0] valid_cnt_reg, valid_cnt_next;
    logic valid_reg, valid_next;
    logic [23:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    raa_range_t range_out_reg, range_out_next;
    raa_alert_t trip;
    raa_alert_t status;
    logic cause_read;

    // the latched range word normally follows host writes; a snapshot overrides
    // a write landing in the same cycle, because the image must match the result
    // set that the snapshot froze rather than settings that were never measured
    // latched_valid drops on the snapshot edge and rises once the count runs out;
    // a second snapshot inside the window simply restarts the wait
    // snapshot freezes the settings that produced the result set
    always_comb begin
        range_next = range_reg;
        accum_next = accum_reg;
        valid_cnt_next = valid_cnt_reg;
        valid_next = valid_reg;
        if (req.wr && req.addr == RAA_OFS_LATCHED_RANGE) begin
            range_next = req.wdata[15:0];
        end
        if (req.wr && req.addr == RAA_OFS_ACCUM_MODE) begin
            accum_next = acc_clean(req.wdata[7:0]);
        end
        if (snapshot_cmd) begin
            range_next = range_live;
            valid_next = 1'b0;
            valid_cnt_next = CNT_LOAD;
        end else if (valid_cnt_reg != '0) begin
            // count down the 1 ms settling of the result set
            valid_cnt_next = valid_cnt_reg - 24'h00_0001;
            valid_next = (valid_cnt_reg == 24'h00_0001);
        end
    end

    // reset returns all settings to unipolar ranges and power accumulation
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            range_reg <= RAA_RANGE_RESET;
            accum_reg <= RAA_ACCUM_RESET;
            valid_cnt_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            range_reg <= range_next;
            accum_reg <= accum_next;
            valid_cnt_reg <= valid_cnt_next;
            valid_reg <= valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reserved range code 11 is passed through untouched; the front end decides
    // how to treat it, this block only stores and forwards it
    // decoding from the next value lets the outputs change on the same edge as
    // the register instead of one cycle behind it
    // range fields decoded for the front end; registered so outputs come from flops
    always_comb begin
        range_out_next.sense_range_ch4 = fsr_at(range_next, RAA_POS_SENSE_CH4);
        range_out_next.bus_range_ch1 = fsr_at(range_next, RAA_POS_BUS_CH1);
        range_out_next.bus_range_ch2 = fsr_at(range_next, RAA_POS_BUS_CH2);
        range_out_next.bus_range_ch3 = fsr_at(range_next, RAA_POS_BUS_CH3);
        range_out_next.bus_range_ch4 = fsr_at(range_next, RAA_POS_BUS_CH4);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            range_out_reg <= raa_range_t'(10'h000);
        end else begin
            range_out_reg <= range_out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // only enabled comparators can trip; enables reset low outside this block
    // the accumulator and count overflow bits are not gated: no enable exists
    // for them, and a lost overflow would silently corrupt an energy total
    // the two unused low bits are forced to zero here and again in the bank
    // with enables low after reset, no comparator field can trip until set
    always_comb begin
        trip = compare_hit & alert_enable;
        trip.accumulator_overflow = |(acc_overflow | acc_limit_hit);
        trip.sample_count_overflow = count_overflow;
        trip.unused = 2'b00;
    end

    assign cause_read = req.rd && req.addr == RAA_OFS_ALERT_CAUSE;

    // the bank keeps its own read mark, so a read and a conversion end in the
    // same cycle still clear what that read returned
    // flags set after the read are not marked and survive the next clear
    // sticky cause flags, layout fixed by the struct
    raa_alert_bank u_alert_bank (
        .ref_clk(ref_clk),
        .rst(rst),
        .trip(trip),
        .read_strobe(cause_read),
        .conv_done(conv_done),
        .status(status)
    );

    ////////////////////////////////////////////////////////////////////////////
    // rd_data holds its last word between reads so a slow bus engine may take it
    // late; rd_valid marks the one cycle in which a fresh word arrived
    // the strobe is sampled on every edge; holding rd high for two edges reads twice
    // reading the cause register also arms its clear inside the alert bank
    // read mux, one cycle after the strobe; unmapped pointers read zero
    always_comb begin
        rd_data_next = rd_data_reg;
        rd_valid_next = req.rd;
        if (req.rd) begin
            unique case (req.addr)
                RAA_OFS_LATCHED_RANGE: rd_data_next = {8'h00, range_reg};
                RAA_OFS_ACCUM_MODE: rd_data_next = {16'h0000, accum_reg};
                RAA_OFS_ALERT_CAUSE: rd_data_next = status;
                default: rd_data_next = 24'h00_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 24'h00_0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // every output below comes straight from a flip-flop, so downstream timing
    // sees no decode logic behind these pins
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign range_latched = range_out_reg;
    assign latched_valid = valid_reg;
    assign accum_mode = accum_reg;
    assign alert_flags = status;

endmodule : raa_regs

// ==== verification/raa_host.sv ====
// host model issuing one-cycle register strobes
`timescale 1ns/1ps
module raa_host
    import raa_pkg::*;
(
    // clock and answer
    input wire logic ref_clk,
    input wire logic [23:0] rd_data,
    input wire logic rd_valid,
    // strobes
    output raa_pkg::raa_req_t req
);
    ////////////////////////////////////////////////////////////////////////////
    // idle fields show inverted leftovers so nothing stale passes for live
    initial req = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 24'h00_0000};
    // strobe for one edge, take the settled answer, then leave one idle edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [23:0] d,
        output logic [23:0] q, output logic v);
        req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge ref_clk);
        #1;
        req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
        q = rd_data;
        v = rd_valid;
        @(posedge ref_clk);
        #1;
    endtask : xfer
endmodule : raa_host

// ==== verification/raa_regs_chk.sv ====
// checker for the range, accumulator and alert register bank
`timescale 1ns/1ps
module raa_regs_chk
    import raa_pkg::*;
#(
    parameter int LATCH_VALID_CYC = raa_pkg::RAA_LATCH_VALID_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // inputs watched
    input wire raa_pkg::raa_req_t req,
    input wire logic snapshot_cmd,
    input wire raa_pkg::raa_alert_t compare_hit,
    input wire raa_pkg::raa_alert_t alert_enable,
    input wire logic [3:0] acc_limit_hit,
    input wire logic count_overflow,
    input wire logic conv_done,
    // outputs watched
    input wire logic [23:0] rd_data,
    input wire logic latched_valid,
    input wire logic [7:0] accum_mode,
    input wire raa_pkg::raa_alert_t alert_flags
);
    logic [23:0] f;
    logic [23:0] trip;
    int cnt_reg;
    int cnt_next;
    ////////////////////////////////////////////////////////////////////////////
    // only the comparator fields are gated by enables
    assign f = alert_flags;
    assign trip = compare_hit & alert_enable & 24'hFF_FFF0;
    // cycles since the last snapshot, saturating so it never wraps
    always_comb begin
        cnt_next = cnt_reg;
        if (snapshot_cmd) begin
            cnt_next = 1;
        end else if (cnt_reg != 0 && cnt_reg <= LATCH_VALID_CYC) begin
            cnt_next = cnt_reg + 1;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    cause_read_a: assert property (req.rd && req.addr == RAA_OFS_ALERT_CAUSE
        |=> rd_data == $past(f)) else $error("cause read data wrong");
    trip_set_a: assert property (1 |=> ($past(trip) & ~f) == 0)
        else $error("enabled trip not flagged");
    gated_quiet_a: assert property (f[23:4] == 0 && trip == 0 |=> f[23:4] == 0)
        else $error("flag set without enabled trip");
    acc_full_a: assert property (|acc_limit_hit |=> f[3])
        else $error("accumulator fullness not flagged");
    count_full_a: assert property (count_overflow |=> f[2])
        else $error("count overflow not flagged");
    low_zero_a: assert property (f[1:0] == 2'b00)
        else $error("unused flag bits set");
    sticky_flag_a: assert property (!conv_done |=> (f & $past(f)) == $past(f))
        else $error("flag cleared without conversion end");
    accum_rsvd_a: assert property ((accum_mode & (accum_mode >> 1) & 8'h55) == 0)
        else $error("reserved accumulator code held");
    valid_time_a: assert property (latched_valid == (cnt_reg > LATCH_VALID_CYC))
        else $error("snapshot valid at wrong time");
    cover property (snapshot_cmd);
    cover property (conv_done && f != 0);
    cover property (req.rd && req.addr == RAA_OFS_ALERT_CAUSE);
endmodule : raa_regs_chk
bind raa_regs raa_regs_chk #(.LATCH_VALID_CYC(LATCH_VALID_CYC)) chk (.ref_clk(ref_clk),
    .rst(rst), .req(req), .snapshot_cmd(snapshot_cmd), .compare_hit(compare_hit),
    .alert_enable(alert_enable), .acc_limit_hit(acc_limit_hit),
    .count_overflow(count_overflow), .conv_done(conv_done), .rd_data(rd_data),
    .latched_valid(latched_valid), .accum_mode(accum_mode), .alert_flags(alert_flags));

// ==== verification/raa_regs_test.sv ====
// self-checking bench for the range, accumulator and alert bank
`timescale 1ns/1ps
module raa_regs_test;
    import raa_pkg::*;
    localparam int VC = 20;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic snapshot_cmd, count_overflow, conv_done, rd_valid, latched_valid, v;
    logic [23:0] rd_data, q;
    logic [15:0] range_live;
    logic [7:0] accum_mode;
    logic [3:0] acc_overflow, acc_limit_hit;
    raa_req_t req;
    raa_alert_t compare_hit, alert_enable, alert_flags;
    raa_range_t range_latched;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    // 125 MHz clock; the guard sits far beyond the fewer than a hundred cycles needed
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end
    raa_host host (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));
    raa_regs #(.LATCH_VALID_CYC(VC)) dut (.ref_clk(ref_clk), .rst(rst), .req(req),
        .rd_data(rd_data), .rd_valid(rd_valid), .snapshot_cmd(snapshot_cmd),
        .range_live(range_live), .compare_hit(compare_hit), .alert_enable(alert_enable),
        .acc_overflow(acc_overflow), .acc_limit_hit(acc_limit_hit),
        .count_overflow(count_overflow), .conv_done(conv_done),
        .range_latched(range_latched), .latched_valid(latched_valid),
        .accum_mode(accum_mode), .alert_flags(alert_flags));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    // a read passes its expected word as d; the block ignores data on reads
    task automatic bus(input logic [7:0] a, input logic w, input logic [23:0] d);
        host.xfer(a, w, d, q, v);
        if (!w) begin
            chk("rd_valid", {23'h00_0000, v}, 24'h00_0001);
            chk("rd_data", q, d);
        end else begin
            chk("rd_valid", {23'h00_0000, v}, 24'h00_0000);
        end
    endtask : bus
    task automatic conv();
        conv_done = 1'b1;
        step(1);
        conv_done = 1'b0;
    endtask : conv
    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_accum();
        logic [7:0] w [3] = '{8'h9E, 8'h1B, 8'hE4};
        logic [7:0] e [3] = '{8'h92, 8'h18, 8'h24};
        bus(8'h25, 1'b0, 24'h00_0000); // reset value
        for (int i = 0; i < 3; i++) begin
            bus(8'h25, 1'b1, {16'h0000, w[i]});
            chk("accum_mode", {16'h0000, accum_mode}, {16'h0000, e[i]}); // codes
            bus(8'h25, 1'b0, {16'h0000, e[i]}); // readback
        end
        bus(8'h26, 1'b1, 24'hFF_FFFF);
        bus(8'h30, 1'b1, 24'hFF_FFFF);
        bus(8'h26, 1'b0, 24'h00_0000); // cause not writable
        bus(8'h30, 1'b0, 24'h00_0000);
    endtask : t_accum
    // every code in some field, then a snapshot of other live settings
    task automatic t_range();
        bus(8'h24, 1'b1, 24'h00_026C);
        chk("range_latched", {14'h0000, range_latched}, 24'h00_026C); // fields
        bus(8'h24, 1'b0, 24'h00_026C); // codes
        range_live = 16'h0193;
        snapshot_cmd = 1'b1;
        step(1);
        snapshot_cmd = 1'b0;
        step(VC - 1);
        chk("latched_valid", {23'h00_0000, latched_valid}, 24'h00_0000); // early
        step(1);
        chk("latched_valid", {23'h00_0000, latched_valid}, 24'h00_0001); // on time
        bus(8'h24, 1'b0, 24'h00_0193); // image
        chk("range_latched", {14'h0000, range_latched}, 24'h00_0193); // frozen
    endtask : t_range
    task automatic t_alert();
        compare_hit = 24'hFF_FFF0;
        step(2);
        chk("alert_flags", alert_flags, 24'h00_0000); // disabled
        alert_enable = 24'hFF_FFF0; // host enables trips
        compare_hit = 24'h81_4280;
        acc_limit_hit = 4'h2;
        count_overflow = 1'b1;
        step(1);
        bus(8'h26, 1'b0, 24'h81_428C); // layout
        compare_hit = 24'h80_0000;
        {acc_limit_hit, count_overflow} = 5'h00;
        conv();
        chk("alert_flags", alert_flags, 24'h80_0000); // clear, held bit
        bus(8'h26, 1'b0, 24'h80_0000);
        compare_hit = 24'h00_0000;
        conv();
        chk("alert_flags", alert_flags, 24'h00_0000); // cleared
        acc_overflow = 4'h1;
        step(1);
        acc_overflow = 4'h0;
        conv();
        chk("alert_flags", alert_flags, 24'h00_0008); // no read, no clear
        bus(8'h26, 1'b0, 24'h00_0008);
        acc_overflow = 4'h1;
        conv();
        acc_overflow = 4'h0;
        chk("alert_flags", alert_flags, 24'h00_0008); // set beats clear
    endtask : t_alert
    initial begin
        {snapshot_cmd, count_overflow, conv_done} = 3'h0;
        {acc_overflow, acc_limit_hit, range_live} = 24'h00_0000;
        {compare_hit, alert_enable} = 48'h0000_0000_0000;
        step(8);
        rst = 1'b0;
        t_accum();
        t_range();
        t_alert();
        conclude();
    end
endmodule : raa_regs_test
